// ==== logic/dcsw_defs.vh ====
// Bit positions, encodings and reset values for the drive command word, plus the thermal full-scale level for the state word
`ifndef DCSW_DEFS_VH
`define DCSW_DEFS_VH
`define DCSW_CMD_RESET      16'h0000
`define DCSW_CB_DCBRAKE_N   2
`define DCSW_CB_COAST_N     3
`define DCSW_CB_QSTOP_N     4
`define DCSW_CB_HOLD_N      5
`define DCSW_CB_RUN         6
`define DCSW_CB_RESET       7
`define DCSW_CB_JOG         8
`define DCSW_CB_RAMP2       9
`define DCSW_CB_VALID       10
`define DCSW_CB_RELAY1      11
`define DCSW_CB_RELAY4      12
`define DCSW_CB_SETUP_LO    13
`define DCSW_CB_SETUP_HI    14
`define DCSW_CB_REVERSE     15
`define DCSW_RELAY1_FUNC    8'h24
`define DCSW_RELAY4_FUNC    8'h25
`define DCSW_MULTI_SETUP    4'h9
`define DCSW_SETUP_RESET    2'h0
`define DCSW_THERM_FULL     8'h64
`endif

// ==== logic/dcsw_control_status.v ====
// Drive command word decoder and drive state word builder
// Operation
// - Command bit 4 low ramps motor to stop over quick-stop ramp time.
// - Command bit 5 low freezes output frequency; only speed-up/slow-down inputs change it.
// - While frozen, only coast bit, DC-brake bit or DC/coast inputs stop the motor.
// - Command bit 6 low ramp-stops with selected ramp; high permits start.
// - Trip clears only on a rising edge of command bit 7.
// - Command bit 8 high selects jog speed as output frequency.
// - Command bit 9 selects ramp set one (low) or two (high).
// - Whole command word ignored unless bit 10 is high.
// - Command bit 11 energizes relay one only when its function is option 36.
// - Command bit 12 energizes relay four only when its function is option 37.
// - Command bits 14:13 select set-up one to four when active set-up is option 9.
// - Command bit 15 reverses direction if direction setting allows it.
// - State bit 0 low when tripped, high when controls ready.
// - State bit 1 high when ready but a coast command is active.
// - State bit 2 low when motor released, high when start possible.
// - State bits 3, 4, 6 flag trip, error without trip and locked trip.
// - State bit 7 flags a warning; bit 5 always reads zero.
// - State bit 8 high when speed equals reference, low while ramping.
// - State bit 9 low under local stop or local reference, high for bus control.
// - State bit 10 high while output frequency sits inside speed limits.
// - State bit 11 high on start signal or nonzero frequency.
// - State bits 12 to 15 flag brake stop, DC link voltage, torque and thermal timer.
// - Command bit 3 low shuts off output stage immediately, motor coasts.
// - Command bit 2 low applies DC braking unless a coast command is active; high allows normal ramping.
`timescale 1ns/1ps
`include "dcsw_defs.vh"

module dcsw_control_status #(
	parameter CMD_WIDTH = 16,
	parameter THERM_W   = 8
) (
	input  wire                 sys_clk,
	input  wire                 resetn,
	input  wire                 cmdWrite,
	input  wire [CMD_WIDTH-1:0] cmdWord,
	input  wire [7:0]           relay1Function,
	input  wire [7:0]           relay4Function,
	input  wire [3:0]           activeSetupMode,
	input  wire                 reverseAllowed,
	input  wire                 dinSpeedUp,
	input  wire                 dinSlowDown,
	input  wire                 dinDcBrake,
	input  wire                 dinCoast,
	input  wire                 dinResetCoast,
	input  wire                 tripActive,
	input  wire                 tripLocked,
	input  wire                 errorNoTrip,
	input  wire                 warningActive,
	input  wire                 speedAtRef,
	input  wire                 localStopActive,
	input  wire                 localRefActive,
	input  wire                 atLowLimit,
	input  wire                 atHighLimit,
	input  wire                 freqNonZero,
	input  wire                 startSignal,
	input  wire                 brakeFault,
	input  wire                 dcLinkOutOfRange,
	input  wire                 torqueExceeded,
	input  wire [THERM_W-1:0]   motorThermPct,
	input  wire [THERM_W-1:0]   inverterThermPct,
	output reg                  quickStopRamp,
	output reg                  holdFrequency,
	output reg                  freqUp,
	output reg                  freqDown,
	output reg                  rampStop,
	output reg                  startPermit,
	output reg                  tripResetPulse,
	output reg                  jogSelect,
	output reg                  rampSet2,
	output reg                  relay1On,
	output reg                  relay4On,
	output reg  [1:0]           activeSetup,
	output reg                  reverseDir,
	output reg                  outputStageOff,
	output reg                  dcBrakeOn,
	output reg  [15:0]          driveStateWord
);

	// Internal state
	reg [CMD_WIDTH-1:0] cmd_q;
	reg                 resetBit_q;
	reg                 dinUp_m;
	reg                 dinUp_q;
	reg                 dinDn_m;
	reg                 dinDn_q;
	reg                 dinDc_m;
	reg                 dinDc_q;
	reg                 dinCo_m;
	reg                 dinCo_q;
	reg                 dinRc_m;
	reg                 dinRc_q;
	wire                coastCmd;
	wire                dcCmd;
	wire                frozen;
	wire                thermOver;
	wire [15:0]         state_d;

	// Thermal timer past full scale
	function overFull;
		input [THERM_W-1:0] pct;
		begin
			overFull = (pct > `DCSW_THERM_FULL);
		end
	endfunction

	// Drive neither tripped nor locked
	function driveReady;
		input trip;
		input locked;
		begin
			driveReady = !trip && !locked;
		end
	endfunction

	// Speed-up pin synchroniser
	always @(posedge sys_clk) begin
		if (!resetn) begin
			dinUp_m <= 1'b0;
			dinUp_q <= 1'b0;
		end else begin
			dinUp_m <= dinSpeedUp;
			dinUp_q <= dinUp_m;
		end
	end

	// Slow-down pin synchroniser
	always @(posedge sys_clk) begin
		if (!resetn) begin
			dinDn_m <= 1'b0;
			dinDn_q <= 1'b0;
		end else begin
			dinDn_m <= dinSlowDown;
			dinDn_q <= dinDn_m;
		end
	end

	// DC brake pin synchroniser
	always @(posedge sys_clk) begin
		if (!resetn) begin
			dinDc_m <= 1'b0;
			dinDc_q <= 1'b0;
		end else begin
			dinDc_m <= dinDcBrake;
			dinDc_q <= dinDc_m;
		end
	end

	// Coast pin synchroniser
	always @(posedge sys_clk) begin
		if (!resetn) begin
			dinCo_m <= 1'b0;
			dinCo_q <= 1'b0;
		end else begin
			dinCo_m <= dinCoast;
			dinCo_q <= dinCo_m;
		end
	end

	// Reset-and-coast pin synchroniser
	always @(posedge sys_clk) begin
		if (!resetn) begin
			dinRc_m <= 1'b0;
			dinRc_q <= 1'b0;
		end else begin
			dinRc_m <= dinResetCoast;
			dinRc_q <= dinRc_m;
		end
	end

	// Latch command word only when marked valid
	always @(posedge sys_clk) begin
		if (!resetn) begin
			cmd_q <= `DCSW_CMD_RESET;
		end else if (cmdWrite && cmdWord[`DCSW_CB_VALID]) begin
			cmd_q <= cmdWord;
		end
	end

	// Previous stored reset bit for edge detection
	always @(posedge sys_clk) begin
		if (!resetn) begin
			resetBit_q <= 1'b0;
		end else begin
			resetBit_q <= cmd_q[`DCSW_CB_RESET];
		end
	end

	assign coastCmd = !cmd_q[`DCSW_CB_COAST_N] || dinCo_q || dinRc_q;
	assign dcCmd    = !cmd_q[`DCSW_CB_DCBRAKE_N] || dinDc_q;
	assign frozen   = !cmd_q[`DCSW_CB_HOLD_N];
	// Either thermal timer over full scale
	assign thermOver = overFull(motorThermPct) || overFull(inverterThermPct);

	// Stop paths: coast, DC brake, quick stop, ramp stop
	always @(posedge sys_clk) begin
		if (!resetn) begin
			outputStageOff <= 1'b0;
			dcBrakeOn      <= 1'b0;
			quickStopRamp  <= 1'b0;
			rampStop       <= 1'b0;
			startPermit    <= 1'b0;
		end else begin
			outputStageOff <= coastCmd;
			dcBrakeOn      <= dcCmd && !coastCmd;
			quickStopRamp  <= !frozen && !cmd_q[`DCSW_CB_QSTOP_N];
			rampStop       <= !frozen && !cmd_q[`DCSW_CB_RUN];
			startPermit    <= cmd_q[`DCSW_CB_RUN];
		end
	end

	// Frequency source: freeze, pins, jog, ramp set
	always @(posedge sys_clk) begin
		if (!resetn) begin
			holdFrequency <= 1'b0;
			freqUp        <= 1'b0;
			freqDown      <= 1'b0;
			jogSelect     <= 1'b0;
			rampSet2      <= 1'b0;
		end else begin
			holdFrequency <= frozen;
			freqUp        <= frozen && dinUp_q && !dinDn_q;
			freqDown      <= frozen && dinDn_q && !dinUp_q;
			jogSelect     <= cmd_q[`DCSW_CB_JOG];
			rampSet2      <= cmd_q[`DCSW_CB_RAMP2];
		end
	end

	// Trip reset on rising stored reset bit
	always @(posedge sys_clk) begin
		if (!resetn) begin
			tripResetPulse <= 1'b0;
		end else begin
			tripResetPulse <= cmd_q[`DCSW_CB_RESET] && !resetBit_q;
		end
	end

	// Relays gated by their function setting
	always @(posedge sys_clk) begin
		if (!resetn) begin
			relay1On <= 1'b0;
			relay4On <= 1'b0;
		end else begin
			relay1On <= cmd_q[`DCSW_CB_RELAY1] && (relay1Function == `DCSW_RELAY1_FUNC);
			relay4On <= cmd_q[`DCSW_CB_RELAY4] && (relay4Function == `DCSW_RELAY4_FUNC);
		end
	end

	// Set-up select, holds outside multi-set-up
	always @(posedge sys_clk) begin
		if (!resetn) begin
			activeSetup <= `DCSW_SETUP_RESET;
		end else if (activeSetupMode == `DCSW_MULTI_SETUP) begin
			activeSetup <= {cmd_q[`DCSW_CB_SETUP_HI], cmd_q[`DCSW_CB_SETUP_LO]};
		end
	end

	// Direction, only where reversing is allowed
	always @(posedge sys_clk) begin
		if (!resetn) begin
			reverseDir <= 1'b0;
		end else begin
			reverseDir <= cmd_q[`DCSW_CB_REVERSE] && reverseAllowed;
		end
	end

	// State word: readiness and coast
	assign state_d[0]  = driveReady(tripActive, tripLocked);
	assign state_d[1]  = driveReady(tripActive, tripLocked) && coastCmd;
	assign state_d[2]  = !coastCmd;

	// Fault and warning flags
	assign state_d[3]  = tripActive;
	assign state_d[4]  = errorNoTrip;
	assign state_d[5]  = 1'b0;
	assign state_d[6]  = tripLocked;
	assign state_d[7]  = warningActive;

	// Speed, control site and limits
	assign state_d[8]  = speedAtRef;
	assign state_d[9]  = !localStopActive && !localRefActive;
	assign state_d[10] = !atLowLimit && !atHighLimit;
	assign state_d[11] = startSignal || freqNonZero;

	// Protection flags
	assign state_d[12] = brakeFault;
	assign state_d[13] = dcLinkOutOfRange;
	assign state_d[14] = torqueExceeded;
	assign state_d[15] = thermOver;

	always @(posedge sys_clk) begin
		if (!resetn) begin
			driveStateWord <= 16'h0000;
		end else begin
			driveStateWord <= state_d;
		end
	end

endmodule // dcsw_control_status

// ==== sim/dcsw_assertions.sv ====
// Assertion checker for the command and state word block
`timescale 1ns/1ps
module dcsw_assertions (
	input wire        sys_clk, resetn, cmdWrite, tripActive, tripLocked, errorNoTrip, warningActive,
	input wire        reverseAllowed, holdFrequency, quickStopRamp, rampStop, tripResetPulse,
	input wire        jogSelect, relay1On, reverseDir, outputStageOff,
	input wire [15:0] cmdWord, driveStateWord,
	input wire [7:0]  relay1Function
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!resetn);
	reg  rst7_q;
	wire take = cmdWrite && cmdWord[10];
	wire rise = take && cmdWord[7] && !rst7_q;
	always @(posedge sys_clk) rst7_q <= !resetn ? 1'b0 : (take ? cmdWord[7] : rst7_q);
	a_jog_select: assert property (take |-> ##2 jogSelect == $past(cmdWord[8], 2)) else $error("jog wrong");
	a_relay_one: assert property (take |-> ##2 relay1On == ($past(cmdWord[11], 2) && relay1Function == 8'h24))
		else $error("relay one wrong");
	a_reverse_dir: assert property (take |-> ##2 reverseDir == ($past(cmdWord[15], 2) && reverseAllowed))
		else $error("reverse wrong");
	a_coast_stage: assert property (take |-> ##2 outputStageOff == !$past(cmdWord[3], 2))
		else $error("coast wrong");
	a_freeze_hold: assert property (take && !cmdWord[5] |-> ##2 holdFrequency && !quickStopRamp && !rampStop)
		else $error("freeze wrong");
	a_trip_edge: assert property (take |-> ##2 tripResetPulse == $past(rise, 2)) else $error("trip reset wrong");
	a_trip_once: assert property (tripResetPulse |=> !tripResetPulse) else $error("pulse too long");
	a_fault_flags: assert property ($past(resetn) |-> driveStateWord[0] == !$past(tripActive || tripLocked) &&
		driveStateWord[7:3] == $past({warningActive, tripLocked, 1'b0, errorNoTrip, tripActive}))
		else $error("fault flags wrong");
	c_trip_reset: cover property (tripResetPulse);
	c_frozen_coast: cover property (holdFrequency && outputStageOff);
	c_relay_on: cover property (relay1On && reverseDir);
endmodule // dcsw_assertions

// ==== sim/dcsw_node_model.sv ====
// Network node model that sends command words
`timescale 1ns/1ps
module dcsw_node_model (
	input  wire         sys_clk,
	output logic        cmdWrite,
	output logic [15:0] cmdWord
);
	initial begin
		cmdWrite = 1'b0;
		cmdWord  = 16'h0000;
	end
	task send(input logic [15:0] w);
		@(negedge sys_clk);
		cmdWrite = 1'b1;
		cmdWord  = w;
		@(negedge sys_clk);
		cmdWrite = 1'b0;
		cmdWord  = ~w;
	endtask
endmodule // dcsw_node_model

// ==== sim/dcsw_control_status_tb.sv ====
// Testbench for the command and state word block
`timescale 1ns/1ps
module dcsw_control_status_tb;
	logic        sys_clk = 1'b0;
	logic        resetn = 1'b0;
	logic        revOk = 1'b1;
	logic [3:0]  mode = 4'h9;
	logic [4:0]  din = 5'h00;
	logic [7:0]  r1F = 8'h24, r4F = 8'h25, mTh = 8'h64, iTh = 8'h64;
	logic [13:0] st = 14'h0000;
	wire         cmdWrite;
	wire  [15:0] cmdWord, o, sw;
	int          err_count = 0, num_checks = 0;
	always #2.5 sys_clk = ~sys_clk;
	dcsw_node_model i_node (.sys_clk(sys_clk), .cmdWrite(cmdWrite), .cmdWord(cmdWord));
	dcsw_control_status i_dut (.sys_clk(sys_clk), .resetn(resetn), .cmdWrite(cmdWrite), .cmdWord(cmdWord),
		.relay1Function(r1F), .relay4Function(r4F), .activeSetupMode(mode),
		.reverseAllowed(revOk), .dinSpeedUp(din[0]), .dinSlowDown(din[1]), .dinDcBrake(din[2]), .dinCoast(din[3]),
		.dinResetCoast(din[4]), .tripActive(st[0]), .tripLocked(st[1]), .errorNoTrip(st[2]), .warningActive(st[3]),
		.speedAtRef(st[4]), .localStopActive(st[5]), .localRefActive(st[6]), .atLowLimit(st[7]), .atHighLimit(st[8]),
		.freqNonZero(st[9]), .startSignal(st[10]), .brakeFault(st[11]), .dcLinkOutOfRange(st[12]),
		.torqueExceeded(st[13]), .motorThermPct(mTh), .inverterThermPct(iTh), .quickStopRamp(o[0]),
		.holdFrequency(o[1]), .freqUp(o[2]), .freqDown(o[3]), .rampStop(o[4]), .startPermit(o[5]),
		.tripResetPulse(o[6]), .jogSelect(o[7]), .rampSet2(o[8]), .relay1On(o[9]), .relay4On(o[10]),
		.reverseDir(o[11]), .outputStageOff(o[12]), .dcBrakeOn(o[13]), .activeSetup(o[15:14]), .driveStateWord(sw));
	task chk(input logic [15:0] got, exp);
		num_checks++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task wrap_up;
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task sendw(input logic [15:0] w, e);
		i_node.send(w);
		repeat (2) @(negedge sys_clk);
		chk(o, e);
	endtask
	task pulses(input logic [15:0] w, n);
		logic [15:0] c;
		c = 16'h0000;
		i_node.send(w);
		repeat (4) begin
			@(negedge sys_clk);
			c = c + (o[6] === 1'b1);
		end
		chk(c, n);
	endtask
	task test_decode;
		sendw(16'hff7c, 16'hcfa0);
		r1F = 8'h23;
		r4F = 8'h26;
		revOk = 1'b0;
		mode = 4'h1;
		sendw(16'hbc3c, 16'hc010);
		sendw(16'h03c0, 16'hc010);
		$display("decode test done");
	endtask
	task test_stop;
		sendw(16'h0428, 16'he011);
		chk(sw[2:1], 2'b10);
		sendw(16'h040c, 16'hc002);
		din[0] = 1'b1;
		repeat (4) @(negedge sys_clk);
		chk(o, 16'hc006);
		din = 5'h03;
		repeat (4) @(negedge sys_clk);
		chk(o, 16'hc002);
		din = 5'h02;
		repeat (4) @(negedge sys_clk);
		chk(o, 16'hc00a);
		din = 5'h04;
		repeat (4) @(negedge sys_clk);
		chk(o, 16'he002);
		din = 5'h08;
		repeat (4) @(negedge sys_clk);
		chk(o, 16'hd002);
		din = 5'h10;
		repeat (4) @(negedge sys_clk);
		chk(o, 16'hd002);
		din = 5'h00;
		sendw(16'h0404, 16'hd002);
		chk(sw[2:1], 2'b01);
		$display("stop test done");
	endtask
	task test_trip;
		pulses(16'h04fc, 16'h0001);
		pulses(16'h04fc, 16'h0000);
		pulses(16'h047c, 16'h0000);
		pulses(16'h04fc, 16'h0001);
		$display("trip test done");
	endtask
	task test_status;
		logic [15:0] e;
		for (int i = 0; i < 16; i++) begin
			st = (i < 14) ? 14'h0001 << i : 14'h0000;
			mTh = (i == 14) ? 8'h65 : 8'h64;
			iTh = (i == 15) ? 8'h65 : 8'h64;
			e = {mTh > 8'h64 || iTh > 8'h64, st[13:11], st[10] | st[9], !(st[7] | st[8]), !(st[5] | st[6]),
				st[4:3], st[1], 1'b0, st[2], st[0], 1'b1, 1'b0, !(st[0] | st[1])};
			@(negedge sys_clk);
			chk(sw, e);
		end
		$display("status test done");
	endtask
	initial begin
		repeat (8) @(negedge sys_clk);
		resetn = 1'b1;
		test_decode();
		test_stop();
		test_trip();
		test_status();
		wrap_up();
	end
	initial begin
		#20000;
		err_count++;
		wrap_up();
	end
endmodule // dcsw_control_status_tb
bind dcsw_control_status dcsw_assertions i_chk (.sys_clk(sys_clk), .resetn(resetn), .cmdWrite(cmdWrite),
	.tripActive(tripActive), .tripLocked(tripLocked), .errorNoTrip(errorNoTrip), .warningActive(warningActive),
	.reverseAllowed(reverseAllowed), .holdFrequency(holdFrequency), .quickStopRamp(quickStopRamp),
	.rampStop(rampStop), .tripResetPulse(tripResetPulse), .jogSelect(jogSelect), .relay1On(relay1On),
	.reverseDir(reverseDir), .outputStageOff(outputStageOff), .cmdWord(cmdWord), .driveStateWord(driveStateWord),
	.relay1Function(relay1Function));
